/* hdl/cbw_defines.vh */
// Constants for the carbon dioxide benchmark and warm-up controller
// What this block does
// - Benchmark voltage reads as 400ppm
// - Recompute concentration periodically from voltage difference
// - Lower concentration replaces benchmark with present voltage
// - Output scaling spans 400 to 3000ppm
// - Concentration shown as PWM duty
// - Separate on/off ventilation control output
// - Warm-up timer starts at power-on
// - Normal operation starts itself after warm-up
// - Straps set operating conditions at power-on
// - Strap changes ignored until next reset
// - All outputs inactive during warm-up
// - Strap high 30 minutes, low 120
// - Line test mode exercises outputs
`ifndef CBW_DEFINES_VH
`define CBW_DEFINES_VH
`define CBW_CLK_HZ        10000000
`define CBW_PPM_AMBIENT   12'h190
`define CBW_PPM_MAX       12'hbb8
`define CBW_PPM_SPAN      12'ha28
`define CBW_WARM_SHORT_MIN 8'h1e
`define CBW_WARM_LONG_MIN  8'h78
`define CBW_SEC_PER_MIN   60
`define CBW_CYC_PER_MIN   (`CBW_CLK_HZ * `CBW_SEC_PER_MIN)
`define CBW_MEAS_PERIOD   100000
`define CBW_ST_STRAP      2'h0
`define CBW_ST_WARM       2'h1
`define CBW_ST_RUN        2'h2
`define CBW_ST_TEST       2'h3
`endif

/* hdl/cbw_pwm.v */
// PWM generator for the concentration output
`timescale 1ns/1ps
module cbw_pwm #(
  parameter WIDTH = 12
) (
  clk,
  rstn,
  enable,
  duty,
  pwmOut
);
  input              clk;
  input              rstn;
  input              enable;
  input  [WIDTH-1:0] duty;
  output             pwmOut;

  reg [WIDTH-1:0] cnt_q;
  reg             pwm_q;

  // Duty compared against free-running ramp; full scale is 2**WIDTH
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= {WIDTH{1'b0}};
      pwm_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
      pwm_q <= enable && (cnt_q < duty);
    end
  end
  assign pwmOut = pwm_q;
endmodule

/* hdl/cbw_top.v */
// Benchmark tracking, concentration, warm-up and outputs for CO2 monitor
`timescale 1ns/1ps
`include "cbw_defines.vh"
module cbw_top #(
  parameter        VW           = 12,
  parameter [31:0] CYC_PER_MIN  = `CBW_CYC_PER_MIN,
  parameter [31:0] MEAS_PERIOD  = `CBW_MEAS_PERIOD,
  parameter [11:0] PPM_PER_LSB  = 12'h004,
  parameter [11:0] CTRL_ON_PPM  = 12'h3e8
) (
  input  wire          clk,
  input  wire          rstn,
  input  wire [VW-1:0] sensorVolt,
  input  wire          warmupSelectStrap,
  input  wire          lineTestStrap,
  output wire          ppmPwm,
  output reg           ventCtrl,
  output reg  [11:0]   ppmValue,
  output wire          warmupDone
);

  ////////////////////////////////////////////////////////////////
  // Straps and state
  reg [1:0]    state_q;
  reg          selShort_q;
  reg          testMode_q;
  reg [31:0]   preCnt_q;
  reg [7:0]    minCnt_q;
  reg [31:0]   measCnt_q;
  reg [VW-1:0] bench_q;
  reg          benchValid_q;
  wire [7:0]   warmMin;
  wire         minTick;
  wire         measTick;
  wire         warmEnd;
  wire         runMode;
  wire         testOn;
  reg  [1:0]   state_d;

  assign warmMin = selShort_q ? `CBW_WARM_SHORT_MIN
                              : `CBW_WARM_LONG_MIN;
  assign minTick = (preCnt_q == CYC_PER_MIN - 32'h1);
  assign measTick = (measCnt_q == MEAS_PERIOD - 32'h1);
  assign warmupDone = (state_q == `CBW_ST_RUN) ||
                      (state_q == `CBW_ST_TEST);
  assign runMode = (state_q == `CBW_ST_RUN);
  assign testOn = (state_q == `CBW_ST_TEST);

  // Straps caught once after release, then never looked at again
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      selShort_q <= 1'b0;
      testMode_q <= 1'b0;
    end else if (state_q == `CBW_ST_STRAP) begin
      selShort_q <= warmupSelectStrap;
      testMode_q <= lineTestStrap;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Warm-up timer
  // Prescaler only runs in warm-up so the minute count starts clean
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      preCnt_q <= 32'h0;
    end else if (state_q == `CBW_ST_WARM) begin
      if (minTick) begin
        preCnt_q <= 32'h0;
      end else begin
        preCnt_q <= preCnt_q + 32'h1;
      end
    end
  end

  // Counts whole minutes; stops mattering once warm-up ends
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      minCnt_q <= 8'h0;
    end else if ((state_q == `CBW_ST_WARM) && minTick) begin
      minCnt_q <= minCnt_q + 8'h1;
    end
  end

  assign warmEnd = minTick && (minCnt_q + 8'h1 >= warmMin);

  // Run or test is left only through reset
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= `CBW_ST_STRAP;
    end else begin
      state_q <= state_d;
    end
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      `CBW_ST_STRAP: begin
        state_d = `CBW_ST_WARM;
      end
      `CBW_ST_WARM: begin
        if (warmEnd) begin
          if (testMode_q) begin
            state_d = `CBW_ST_TEST;
          end else begin
            state_d = `CBW_ST_RUN;
          end
        end
      end
      `CBW_ST_RUN: begin
        state_d = `CBW_ST_RUN;
      end
      `CBW_ST_TEST: begin
        state_d = `CBW_ST_TEST;
      end
      default: begin
        state_d = `CBW_ST_STRAP;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Periodic concentration and benchmark tracking
  wire [VW-1:0] dropV;
  wire [31:0]   rawPpm;
  wire [11:0]   clipPpm;
  wire          benchLoad;

  // Voltage falls as CO2 rises: benchmark holds highest reading
  assign dropV = (sensorVolt < bench_q) ? bench_q - sensorVolt
                                        : {VW{1'b0}};
  assign rawPpm = {{(32-VW){1'b0}}, dropV} * {20'h0, PPM_PER_LSB};
  // Equal reading gives ambient, clipped at upper limit
  assign clipPpm = (rawPpm >= {20'h0, `CBW_PPM_SPAN}) ? `CBW_PPM_MAX
                 : `CBW_PPM_AMBIENT + rawPpm[11:0];

  // Tick counter only runs in normal operation
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      measCnt_q <= 32'h0;
    end else if (runMode) begin
      if (measTick) begin
        measCnt_q <= 32'h0;
      end else begin
        measCnt_q <= measCnt_q + 32'h1;
      end
    end
  end

  // First tick seeds the benchmark; a higher reading replaces it
  assign benchLoad = !benchValid_q || (sensorVolt > bench_q);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bench_q      <= {VW{1'b0}};
      benchValid_q <= 1'b0;
    end else if (runMode && measTick && benchLoad) begin
      bench_q      <= sensorVolt;
      benchValid_q <= 1'b1;
    end
  end

  // A reading at or above the benchmark reports ambient
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ppmValue <= `CBW_PPM_AMBIENT;
    end else if (runMode && measTick) begin
      if (benchLoad) begin
        ppmValue <= `CBW_PPM_AMBIENT;
      end else begin
        ppmValue <= clipPpm;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs, silent until warm-up is over
  reg [11:0] duty;
  reg [11:0] testCnt_q;

  // Free-running sweep; bit 11 gives a slow on/off for the fan line
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      testCnt_q <= 12'h0;
    end else if (testOn) begin
      testCnt_q <= testCnt_q + 12'h1;
    end
  end

  // Line test sweeps the duty and toggles control, no sensor needed
  always @* begin
    if (testOn) begin
      duty = {testCnt_q[11:4], 4'h0};
    end else begin
      duty = ppmValue - `CBW_PPM_AMBIENT;
    end
  end

  // Registered so the fan line never glitches on a tick
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ventCtrl <= 1'b0;
    end else if (testOn) begin
      ventCtrl <= testCnt_q[11];
    end else begin
      ventCtrl <= runMode &&
                  (ppmValue >= CTRL_ON_PPM);
    end
  end

  // Ramp free-runs; the enable holds the pin low through warm-up
  cbw_pwm #(
    .WIDTH (12)
  ) uPwm (
    .clk    (clk),
    .rstn   (rstn),
    .enable (warmupDone),
    .duty   (duty),
    .pwmOut (ppmPwm)
  );

endmodule

/* test/cbw_sensor_model.sv */
// Sensor and converter stand-in
`timescale 1ns/1ps
module cbw_sensor_model (
  input  wire        clk,
  input  wire [11:0] level,
  output reg  [11:0] sensorVolt
);
  initial sensorVolt = 12'h000;
  // Converter result lags the analog level by one clock
  always @(posedge clk) begin
    sensorVolt <= level;
  end
endmodule

/* test/cbw_top_assertions.sv */
// Port checker for the CO2 controller
`timescale 1ns/1ps
module cbw_chk #(parameter [31:0] CYC_PER_MIN = 32'h0000000a) (
  input wire        clk,
  input wire        rstn,
  input wire [11:0] sensorVolt,
  input wire        warmupSelectStrap,
  input wire        lineTestStrap,
  input wire        ppmPwm,
  input wire        ventCtrl,
  input wire [11:0] ppmValue,
  input wire        warmupDone
);
  reg        short_q;
  reg        test_q;
  reg [15:0] cnt_q;
  wire [15:0] wc = (short_q ? 16'h001e : 16'h0078) * CYC_PER_MIN[15:0];
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      short_q <= 1'b0;
      test_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      if (cnt_q == 16'h0000) begin
        short_q <= warmupSelectStrap;
        test_q <= lineTestStrap;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_warm_silent: assert property (
    !warmupDone |-> !ppmPwm && !ventCtrl && ppmValue == 12'h190)
    else $error("output in warm-up");
  chk_warm_time: assert property (
    $rose(warmupDone) |-> cnt_q >= wc && cnt_q <= wc + 16'h0002)
    else $error("warm-up length");
  chk_no_early: assert property (
    cnt_q < wc |-> !warmupDone) else $error("early run");
  chk_done_holds: assert property (
    warmupDone |=> warmupDone) else $error("run left");
  chk_ppm_span: assert property (
    ppmValue >= 12'h190 && ppmValue <= 12'hbb8) else $error("ppm span");
  chk_vent_level: assert property (
    warmupDone && !test_q |=> ventCtrl == ($past(ppmValue) >= 12'h3e8))
    else $error("vent level");
  chk_ppm_frozen: assert property (
    $changed(ppmValue) |-> $past(warmupDone)) else $error("early ppm");
  chk_first_ambient: assert property (
    $rose(warmupDone) |-> (ppmValue == 12'h190) [*8])
    else $error("first ppm");
endmodule
bind cbw_top cbw_chk #(.CYC_PER_MIN(CYC_PER_MIN)) u_cbw_chk (.clk(clk),
  .rstn(rstn), .sensorVolt(sensorVolt), .warmupSelectStrap(warmupSelectStrap),
  .lineTestStrap(lineTestStrap), .ppmPwm(ppmPwm), .ventCtrl(ventCtrl),
  .ppmValue(ppmValue), .warmupDone(warmupDone));

/* test/tb.sv */
// Bench for the CO2 warm-up controller
`timescale 1ns/1ps
module tb;
  reg         clk, rstn, warmSel, lineTest, take, pwmTake, testTake;
  reg  [11:0] level, v0;
  reg  [31:0] rnd, q[$];
  wire [11:0] sensorVolt, ppmValue;
  wire        ppmPwm, ventCtrl, warmupDone;
  integer     bad_count, comparisons, cyc, relCyc, hi;
  cbw_sensor_model u_cbw_sensor_model (.clk(clk), .level(level),
    .sensorVolt(sensorVolt));
  cbw_top #(.CYC_PER_MIN(32'h0000000a), .MEAS_PERIOD(32'h00000008)) u_cbw_top (
    .clk(clk), .rstn(rstn), .sensorVolt(sensorVolt),
    .warmupSelectStrap(warmSel), .lineTestStrap(lineTest), .ppmPwm(ppmPwm),
    .ventCtrl(ventCtrl), .ppmValue(ppmValue), .warmupDone(warmupDone));
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  task check(input string what, input [31:0] seen, exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task boot(input s, t, input [31:0] w);
    begin
      rstn = 1'b0;
      warmSel = s;
      lineTest = t;
      repeat (10) @(posedge clk);
      #1 rstn = 1'b1;
      relCyc = cyc;
      q.push_back(w);
      repeat (3) @(posedge clk);
      #1 warmSel = ~s;
      lineTest = ~t;
      wait (warmupDone === 1'b1);
      @(posedge clk);
      #1;
    end
  endtask
  // Three ticks pass so both result and vent have settled
  task step(input [11:0] v, e);
    begin
      level = v;
      repeat (24) @(posedge clk);
      #1 q.push_back({19'h0, e >= 12'h3e8, e});
      take = 1'b1;
      @(posedge clk);
      #1 take = 1'b0;
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (take)
      check("ppm", {19'h0, ventCtrl, ppmValue}, q.pop_front());
    if ($rose(warmupDone))
      check("warm", cyc - relCyc, q.pop_front());
    if (pwmTake)
      check("pwm", hi, q.pop_front());
    if (testTake)
      check("test", {19'h0, ventCtrl, ppmValue}, q.pop_front());
    if (cyc == 12000) begin
      bad_count = bad_count + 1;
      print_verdict;
    end
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    bad_count = 0;
    comparisons = 0;
    cyc = 0;
    take = 1'b0;
    pwmTake = 1'b0;
    testTake = 1'b0;
    rnd = xs(32'h00000027);
    v0 = 12'h800 + {4'h0, rnd[7:0]};
    level = v0;
    boot(1'b1, 1'b0, 32'h0000012d);
    step(v0, 12'h190);
    rnd = xs(rnd);
    step(v0 - {6'h0, rnd[5:0]}, 12'h190 + {4'h0, rnd[5:0], 2'h0});
    step(v0 + 12'h010, 12'h190);
    step(v0 - 12'h279, 12'hbb4);
    step(v0 - 12'h2c0, 12'hbb8);
    // One full ramp at 3000ppm: high for 3000-400 cycles
    hi = 0;
    repeat (4096) begin
      @(posedge clk);
      #1 hi = hi + ppmPwm;
    end
    q.push_back(32'h00000a28);
    pwmTake = 1'b1;
    @(posedge clk);
    #1 pwmTake = 1'b0;
    boot(1'b0, 1'b1, 32'h000004b1);
    repeat (2050) @(posedge clk);
    #1 q.push_back({19'h0, 1'b1, 12'h190});
    testTake = 1'b1;
    @(posedge clk);
    #1 testTake = 1'b0;
    print_verdict;
  end
endmodule
